/* File: src/lcr_seq_pkg.sv */
// Constants, types and timing for the integrator measurement sequencer.
// Functional notes
// - Wait about three seconds after power-on, then apply processor supply.
// - Run display test first, then load default mode and start capacitance measurement.
// - Auto ranging repeats, stepping the range left or right, until suitable.
// - Manual primary range skips the auto ranging cycle entirely.
// - Displays show blanking dashes while auto ranging is in progress.
// - On saturation, change range right after offset null, skipping remaining steps.
// - Range acceptable only if discharge count lies within 162 to 1820.
// - Offset null, then phase adjustment, precede every charge and discharge.
// - Offset null cuts the signal path and enables the zeroing feedback.
// - A settle interval is inserted at every integrator phase change except between the two adjust periods.
// - Phase adjustment is two consecutive periods, each with its own control.
// - Charge applies the detected signal for a fixed predetermined time.
// - Discharge counts 31.83 kHz counting clock periods until zero is reached.
// - Zero flag stops the count; the count is stored as result.
// - Measure the primary value first, then the dissipation factor.
// - Resistance measurements omit the dissipation cycle.
// - Execute times differ for 120 Hz, 1 kHz and 10 kHz operation.
// - Detection phase is selected stepwise with codes zero to three half-pi.
// - Sequencing runs on the processor clock; counting clock derived from it.
package lcr_seq_pkg;
	localparam int unsigned CLK_HZ = 20_000_000;
	localparam int unsigned CLK_MHZ = CLK_HZ / 1_000_000;
	localparam int unsigned SEC_CLK_HZ = 31_830;
	localparam int unsigned SEC_DIV = CLK_HZ / SEC_CLK_HZ;
	localparam int unsigned POWERUP_MS = 3000;
	localparam int unsigned DISPTEST_MS = 500;
	localparam int unsigned POWERUP_CYC = CLK_HZ / 1000 * POWERUP_MS;
	localparam int unsigned DISPTEST_CYC = CLK_HZ / 1000 * DISPTEST_MS;
	localparam int unsigned HOLD_US = 50;
	localparam int unsigned NULL_US = 150;
	localparam int unsigned ADJ_US_120 = 180;
	localparam int unsigned ADJ_US_1K = 100;
	localparam int unsigned ADJ_US_10K = 40;
	localparam int unsigned CHG_US_120 = 200;
	localparam int unsigned CHG_US_1K = 120;
	localparam int unsigned CHG_US_10K = 60;
	localparam logic [25:0] HOLD_LOAD = 26'(HOLD_US * CLK_MHZ - 1);
	localparam logic [25:0] NULL_LOAD = 26'(NULL_US * CLK_MHZ - 1);
	localparam logic [10:0] CNT_LO = 11'h0a2;
	localparam logic [10:0] CNT_HI = 11'h71c;
	localparam logic [10:0] CNT_STOP = 11'h71d;
	localparam logic [11:0] CTRL_OFS = 12'h000;
	localparam logic [11:0] STATUS_OFS = 12'h004;
	localparam logic [11:0] RES_PRI_OFS = 12'h008;
	localparam logic [11:0] RES_DQ_OFS = 12'h00c;
	localparam logic [2:0] RANGE_TOP = 3'h7;

	typedef enum logic [1:0] {FUNC_C, FUNC_L, FUNC_R} func_t;
	typedef enum logic [1:0] {F_120, F_1K, F_10K} freq_t;
	typedef enum logic [3:0] {S_POWER, S_DISPTEST, S_HOLD, S_NULL, S_ADJ1, S_ADJ2, S_CHARGE,
		S_DISCHARGE} seq_state_t;

	typedef struct packed {
		logic parallel_circuit_mode;
		freq_t freq;
		func_t func;
		logic [2:0] manual_range;
		logic auto_range;
	} ctrl_t;
	localparam ctrl_t CTRL_DEFAULT = '{1'b1, F_1K, FUNC_C, 3'h3, 1'b1};

	typedef struct packed {
		seq_state_t state;
		logic measuring_dq;
		logic [2:0] range;
		logic ranging;
		logic dq_over;
		logic pri_over;
		logic done;
	} status_t;

	typedef struct packed {
		logic signal_path;
		logic null_feedback;
		logic phase_adjust_first;
		logic phase_adjust_second;
		logic charge;
		logic discharge;
		logic [1:0] phase_sel;
		logic [2:0] range_sel;
	} fe_t;

	typedef struct packed {
		logic processor_supply;
		logic display_test;
		logic blank;
		logic [2:0] range_ind;
	} panel_t;

	// Timer load for a phase; adjustment and charge times depend on frequency
	function automatic logic [25:0] phase_load(seq_state_t s, freq_t f);
		logic [25:0] v;
		v = 26'h0;
		case (s)
			S_NULL: v = NULL_LOAD;
			S_ADJ1, S_ADJ2: begin
				case (f)
					F_120: v = 26'(ADJ_US_120 * CLK_MHZ - 1);
					F_10K: v = 26'(ADJ_US_10K * CLK_MHZ - 1);
					default: v = 26'(ADJ_US_1K * CLK_MHZ - 1);
				endcase
			end
			S_CHARGE: begin
				case (f)
					F_120: v = 26'(CHG_US_120 * CLK_MHZ - 1);
					F_10K: v = 26'(CHG_US_10K * CLK_MHZ - 1);
					default: v = 26'(CHG_US_1K * CLK_MHZ - 1);
				endcase
			end
			default: v = 26'h0;
		endcase
		return v;
	endfunction
endpackage

/* File: src/counting_clock_gen.sv */
// Counting clock tick generator derived from the processor clock.
`timescale 1ns/1ns
module counting_clock_gen (
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	input wire logic restart,
	output logic tick
);
	localparam logic [9:0] DIV_LAST = 10'(lcr_seq_pkg::SEC_DIV - 1);
	logic [9:0] cnt_r;

	// Restart aligns the first period with the start of discharge
	always_ff @(posedge clk) begin
		if (reset) begin
			cnt_r <= 10'h0;
			tick <= 1'b0;
		end else if (ce) begin
			if (restart || cnt_r == DIV_LAST) begin
				cnt_r <= 10'h0;
			end else begin
				cnt_r <= cnt_r + 10'h1;
			end
			tick <= !restart && cnt_r == DIV_LAST;
		end
	end
endmodule // counting_clock_gen

/* File: src/lcr_integrator_sequencer.sv */
// Measurement sequencer for the integrating impedance front end, with APB registers.
//
// Local design decisions: register access over APB and the placing of the registers.
`timescale 1ns/1ns
module lcr_integrator_sequencer #(
	parameter int unsigned POWERUP_CYCLES = lcr_seq_pkg::POWERUP_CYC,
	parameter int unsigned DISPTEST_CYCLES = lcr_seq_pkg::DISPTEST_CYC
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic saturation_flag,
	input wire logic zero_flag,
	output lcr_seq_pkg::fe_t front_end,
	output lcr_seq_pkg::panel_t panel
);
	typedef struct packed {
		lcr_seq_pkg::seq_state_t state;
		lcr_seq_pkg::seq_state_t after_hold;
		logic [25:0] timer;
		logic dq;
		logic ranging;
		logic [2:0] rng;
		logic [10:0] cnt;
		logic [10:0] res_pri;
		logic [10:0] res_dq;
		logic pri_over;
		logic dq_over;
		logic done;
		logic disp_done;
		lcr_seq_pkg::ctrl_t ctrl;
		lcr_seq_pkg::fe_t fe;
		lcr_seq_pkg::panel_t pan;
		logic tick_restart;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} st_t;

	st_t st_r;
	st_t st_nxt;
	logic tick;
	logic disc_end;
	logic in_window;
	logic step_down;
	logic can_step;
	lcr_seq_pkg::status_t status;

	counting_clock_gen u_count_clk (
		.clk(clk),
		.reset(reset),
		.ce(ce),
		.restart(st_r.tick_restart),
		.tick(tick)
	);

	always_comb begin
		st_nxt = st_r;
		st_nxt.tick_restart = 1'b0;
		st_nxt.pready = 1'b0;
		st_nxt.pslverr = 1'b0;
		status = '{st_r.state, st_r.dq, st_r.rng, st_r.ranging, st_r.dq_over,
			st_r.pri_over, st_r.done};

		// One wait state: the answer comes in the second access cycle
		if (psel && penable && !st_r.pready) begin
			st_nxt.pready = 1'b1;
			st_nxt.prdata = 32'h0;
			case (paddr)
				lcr_seq_pkg::CTRL_OFS: begin
					if (pwrite) begin
						st_nxt.ctrl = lcr_seq_pkg::ctrl_t'(pwdata[8:0]);
					end else begin
						st_nxt.prdata = {23'h0, st_r.ctrl};
					end
				end
				lcr_seq_pkg::STATUS_OFS: begin
					if (pwrite) begin
						if (pwdata[0]) begin
							st_nxt.done = 1'b0;
						end
					end else begin
						st_nxt.prdata = {20'h0, status};
					end
				end
				lcr_seq_pkg::RES_PRI_OFS: begin
					if (!pwrite) begin
						st_nxt.prdata = {21'h0, st_r.res_pri};
					end
				end
				lcr_seq_pkg::RES_DQ_OFS: begin
					if (!pwrite) begin
						st_nxt.prdata = {21'h0, st_r.res_dq};
					end
				end
				default: begin
					st_nxt.pslverr = 1'b1;
				end
			endcase
		end

		if (st_r.timer != 26'h0) begin
			st_nxt.timer = st_r.timer - 26'h1;
		end

		disc_end = st_r.state == lcr_seq_pkg::S_DISCHARGE &&
			(zero_flag || st_r.cnt == lcr_seq_pkg::CNT_STOP);
		in_window = zero_flag && st_r.cnt >= lcr_seq_pkg::CNT_LO &&
			st_r.cnt <= lcr_seq_pkg::CNT_HI;
		step_down = zero_flag && st_r.cnt < lcr_seq_pkg::CNT_LO;
		can_step = step_down ? st_r.rng != 3'h0 : st_r.rng != lcr_seq_pkg::RANGE_TOP;

		case (st_r.state)
			lcr_seq_pkg::S_POWER: begin
				if (st_r.timer == 26'h0) begin
					st_nxt.state = lcr_seq_pkg::S_DISPTEST;
					st_nxt.timer = 26'(DISPTEST_CYCLES - 1);
				end
			end
			lcr_seq_pkg::S_DISPTEST: begin
				if (st_r.timer == 26'h0) begin
					st_nxt.ctrl = lcr_seq_pkg::CTRL_DEFAULT;
					st_nxt.disp_done = 1'b1;
					st_nxt.dq = 1'b0;
					st_nxt.ranging = lcr_seq_pkg::CTRL_DEFAULT.auto_range;
					st_nxt.state = lcr_seq_pkg::S_HOLD;
					st_nxt.after_hold = lcr_seq_pkg::S_NULL;
					st_nxt.timer = lcr_seq_pkg::HOLD_LOAD;
				end
			end
			lcr_seq_pkg::S_HOLD: begin
				if (st_r.timer == 26'h0) begin
					st_nxt.state = st_r.after_hold;
					st_nxt.timer = lcr_seq_pkg::phase_load(st_r.after_hold, st_r.ctrl.freq);
					if (st_r.after_hold == lcr_seq_pkg::S_DISCHARGE) begin
						st_nxt.cnt = 11'h0;
						st_nxt.tick_restart = 1'b1;
					end
				end
			end
			lcr_seq_pkg::S_NULL: begin
				if (st_r.timer == 26'h0) begin
					st_nxt.state = lcr_seq_pkg::S_HOLD;
					st_nxt.timer = lcr_seq_pkg::HOLD_LOAD;
					if (saturation_flag && st_r.ctrl.auto_range && !st_r.dq &&
						st_r.rng != lcr_seq_pkg::RANGE_TOP) begin
						// Fast ranging: skip the rest of the sequence
						st_nxt.rng = st_r.rng + 3'h1;
						st_nxt.ranging = 1'b1;
						st_nxt.after_hold = lcr_seq_pkg::S_NULL;
					end else begin
						st_nxt.after_hold = lcr_seq_pkg::S_ADJ1;
					end
				end
			end
			lcr_seq_pkg::S_ADJ1: begin
				if (st_r.timer == 26'h0) begin
					st_nxt.state = lcr_seq_pkg::S_ADJ2;
					st_nxt.timer = lcr_seq_pkg::phase_load(lcr_seq_pkg::S_ADJ2, st_r.ctrl.freq);
				end
			end
			lcr_seq_pkg::S_ADJ2: begin
				if (st_r.timer == 26'h0) begin
					st_nxt.state = lcr_seq_pkg::S_HOLD;
					st_nxt.after_hold = lcr_seq_pkg::S_CHARGE;
					st_nxt.timer = lcr_seq_pkg::HOLD_LOAD;
				end
			end
			lcr_seq_pkg::S_CHARGE: begin
				if (st_r.timer == 26'h0) begin
					st_nxt.state = lcr_seq_pkg::S_HOLD;
					st_nxt.after_hold = lcr_seq_pkg::S_DISCHARGE;
					st_nxt.timer = lcr_seq_pkg::HOLD_LOAD;
				end
			end
			lcr_seq_pkg::S_DISCHARGE: begin
				if (disc_end) begin
					st_nxt.state = lcr_seq_pkg::S_HOLD;
					st_nxt.after_hold = lcr_seq_pkg::S_NULL;
					st_nxt.timer = lcr_seq_pkg::HOLD_LOAD;
					if (!st_r.dq) begin
						if (st_r.ctrl.auto_range && !in_window && can_step) begin
							// Out of window: another ranging step, no result
							st_nxt.rng = step_down ? st_r.rng - 3'h1 : st_r.rng + 3'h1;
							st_nxt.ranging = 1'b1;
						end else begin
							st_nxt.res_pri = st_r.cnt;
							st_nxt.pri_over = !in_window;
							st_nxt.ranging = 1'b0;
							if (st_r.ctrl.func == lcr_seq_pkg::FUNC_R) begin
								st_nxt.done = 1'b1;
							end else begin
								st_nxt.dq = 1'b1;
							end
						end
					end else begin
						st_nxt.res_dq = st_r.cnt;
						st_nxt.dq_over = !in_window;
						st_nxt.done = 1'b1;
						st_nxt.dq = 1'b0;
					end
				end else if (tick) begin
					st_nxt.cnt = st_r.cnt + 11'h1;
				end
			end
			default: begin
				st_nxt.state = lcr_seq_pkg::S_POWER;
			end
		endcase

		// Manual range bypasses ranging and forces the selected range
		if (!st_nxt.ctrl.auto_range) begin
			st_nxt.ranging = 1'b0;
			st_nxt.rng = st_nxt.ctrl.manual_range;
		end

		st_nxt.fe.signal_path = st_nxt.state == lcr_seq_pkg::S_CHARGE;
		st_nxt.fe.null_feedback = st_nxt.state == lcr_seq_pkg::S_NULL;
		st_nxt.fe.phase_adjust_first = st_nxt.state == lcr_seq_pkg::S_ADJ1;
		st_nxt.fe.phase_adjust_second = st_nxt.state == lcr_seq_pkg::S_ADJ2;
		st_nxt.fe.charge = st_nxt.state == lcr_seq_pkg::S_CHARGE;
		st_nxt.fe.discharge = st_nxt.state == lcr_seq_pkg::S_DISCHARGE;
		// Parallel uses codes 0 and pi/2, series pi and 3pi/2
		st_nxt.fe.phase_sel = {!st_nxt.ctrl.parallel_circuit_mode, st_nxt.dq};
		st_nxt.fe.range_sel = st_nxt.rng;
		st_nxt.pan.processor_supply = st_nxt.state != lcr_seq_pkg::S_POWER;
		st_nxt.pan.display_test = st_nxt.state == lcr_seq_pkg::S_DISPTEST;
		st_nxt.pan.blank = st_nxt.ranging;
		st_nxt.pan.range_ind = st_nxt.rng;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			st_r <= '0;
			st_r.state <= lcr_seq_pkg::S_POWER;
			st_r.after_hold <= lcr_seq_pkg::S_NULL;
			st_r.timer <= 26'(POWERUP_CYCLES - 1);
			st_r.ctrl <= lcr_seq_pkg::CTRL_DEFAULT;
			st_r.rng <= lcr_seq_pkg::CTRL_DEFAULT.manual_range;
			st_r.pan.range_ind <= lcr_seq_pkg::CTRL_DEFAULT.manual_range;
			st_r.fe.range_sel <= lcr_seq_pkg::CTRL_DEFAULT.manual_range;
		end else if (ce) begin
			st_r <= st_nxt;
		end
	end

	assign prdata = st_r.prdata;
	assign pready = st_r.pready;
	assign pslverr = st_r.pslverr;
	assign front_end = st_r.fe;
	assign panel = st_r.pan;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	sequence s_adj1_ends;
		$fell(st_r.fe.phase_adjust_first);
	endsequence

	sequence s_saturated_null_end;
		ce && st_r.state == lcr_seq_pkg::S_NULL && st_r.timer == 26'h0 && saturation_flag &&
			st_r.ctrl.auto_range && !st_r.dq && st_r.rng != lcr_seq_pkg::RANGE_TOP;
	endsequence

	sequence s_primary_accepted;
		ce && disc_end && !st_r.dq && in_window;
	endsequence

	a_supply_after_wait: assert property ($rose(st_r.pan.processor_supply) |->
		$past(st_r.state) == lcr_seq_pkg::S_POWER && $past(st_r.timer) == 26'h0)
		else $error("supply applied before power-up wait ended");

	a_test_before_charge: assert property (st_r.fe.charge |-> st_r.disp_done)
		else $error("charge before display test finished");

	a_blank_auto_only: assert property (st_r.ranging |->
		st_r.pan.blank && st_r.ctrl.auto_range)
		else $error("ranging without blanking or in manual range");

	a_null_paths: assert property (st_r.state == lcr_seq_pkg::S_NULL |->
		st_r.fe.null_feedback && !st_r.fe.signal_path && !st_r.fe.charge)
		else $error("signal path open during offset null");

	a_hold_before_charge: assert property ($rose(st_r.fe.charge) |->
		$past(st_r.state) == lcr_seq_pkg::S_HOLD)
		else $error("charge entered without settle interval");

	a_adjust_pair: assert property (s_adj1_ends |-> st_r.fe.phase_adjust_second)
		else $error("second phase adjust did not follow the first");

	a_saturation_skip: assert property (s_saturated_null_end |=>
		st_r.state == lcr_seq_pkg::S_HOLD && st_r.after_hold == lcr_seq_pkg::S_NULL &&
		st_r.rng == $past(st_r.rng) + 3'h1 && st_r.pan.blank)
		else $error("saturation did not step range after null");

	a_window_result: assert property (s_primary_accepted |=>
		st_r.res_pri == $past(st_r.cnt) && !st_r.pri_over && !st_r.ranging)
		else $error("accepted count not stored as primary result");

	a_out_of_window: assert property (ce && disc_end && !st_r.dq && !in_window &&
		can_step && st_r.ctrl.auto_range |=> st_r.ranging &&
		st_r.res_pri == $past(st_r.res_pri) && st_r.rng != $past(st_r.rng))
		else $error("out-of-window count produced a result");

	a_count_tick: assert property (ce && st_r.state == lcr_seq_pkg::S_DISCHARGE && tick &&
		!disc_end |=> st_r.cnt == $past(st_r.cnt) + 11'h1)
		else $error("discharge count missed a counting clock tick");

	a_count_bound: assert property (st_r.cnt <= lcr_seq_pkg::CNT_STOP)
		else $error("discharge counter passed its stop value");

	a_r_skips_dq: assert property (s_primary_accepted and
		(st_r.ctrl.func == lcr_seq_pkg::FUNC_R) |=> !st_r.dq && st_r.done)
		else $error("resistance measurement entered dissipation cycle");

	a_dq_follows: assert property (s_primary_accepted and
		(st_r.ctrl.func != lcr_seq_pkg::FUNC_R) |=> st_r.dq &&
		st_r.after_hold == lcr_seq_pkg::S_NULL)
		else $error("dissipation cycle did not follow primary");

	a_phase_code: assert property (st_r.fe.charge |->
		st_r.fe.phase_sel[0] == st_r.dq)
		else $error("phase code does not match measurement step");
endmodule // lcr_integrator_sequencer

/* File: test/analog_front_model.sv */
// Behavioural analog front end: integrator, zero detector and saturation detector.
`timescale 1ns/1ns
module analog_front_model (
	input wire logic clk,
	input wire lcr_seq_pkg::fe_t front_end,
	input wire logic sat_cmd,
	input wire logic [15:0] ticks_pri,
	input wire logic [15:0] ticks_dq,
	output logic saturation_flag,
	output logic zero_flag,
	output logic [7:0] dq_runs
);
	int run_cyc;
	int target;
	logic dis_q;
	// The detector only trips while the integrator is being nulled
	assign saturation_flag = sat_cmd & front_end.null_feedback;
	// Crossing lands mid-period so the tick count is unambiguous
	assign target = (front_end.phase_sel[0] ? int'(ticks_dq) : int'(ticks_pri))
		* int'(lcr_seq_pkg::SEC_DIV) + int'(lcr_seq_pkg::SEC_DIV) / 2;
	initial begin
		run_cyc = 0;
		zero_flag = 1'b0;
		dq_runs = 8'h00;
		dis_q = 1'b0;
	end
	always @(posedge clk) begin
		dis_q <= front_end.discharge;
		if (front_end.discharge && !dis_q && front_end.phase_sel[0])
			dq_runs <= dq_runs + 8'h01;
		if (front_end.discharge) begin
			run_cyc <= run_cyc + 1;
			if (run_cyc + 1 >= target)
				zero_flag <= 1'b1;
		end else begin
			run_cyc <= 0;
			zero_flag <= 1'b0;
		end
	end
endmodule // analog_front_model

/* File: test/lcr_integrator_sequencer_tb.sv */
// Self-checking testbench for the integrator measurement sequencer.
`timescale 1ns/1ns
module lcr_integrator_sequencer_tb;
	localparam int PU = 20;
	localparam int DT = 20;
	localparam int LIM = 20000;
	logic clk, reset, psel, penable, pwrite, pready, pslverr, sat_cmd, err;
	logic saturation_flag, zero_flag;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] ticks_pri, ticks_dq;
	logic [7:0] dq_runs, dq0;
	lcr_seq_pkg::fe_t front_end;
	lcr_seq_pkg::panel_t panel;
	int num_errors, compares, cycles;
	lcr_integrator_sequencer #(.POWERUP_CYCLES(PU), .DISPTEST_CYCLES(DT)) dut (.clk(clk),
		.reset(reset), .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.saturation_flag(saturation_flag), .zero_flag(zero_flag), .front_end(front_end),
		.panel(panel));
	analog_front_model partner (.clk(clk), .front_end(front_end), .sat_cmd(sat_cmd),
		.ticks_pri(ticks_pri), .ticks_dq(ticks_dq), .saturation_flag(saturation_flag),
		.zero_flag(zero_flag), .dq_runs(dq_runs));
	always #25 clk = ~clk;
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 100000) begin
			num_errors++;
			complete_run();
		end
	end
	task automatic complete_run();
		if (num_errors == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		compares++;
		if (got !== exp) begin
			$display("BAD %0t %s", $time, msg);
			num_errors++;
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	// Phase index: 0 null, 1 first adjust, 2 second adjust, 3 charge, 4 discharge
	function automatic logic fe_bit(input int sel);
		return front_end[9 - sel];
	endfunction
	task automatic wait_fe(input int sel, input int forbid, input bit settle);
		int n;
		logic prev_idle;
		n = 0;
		do begin
			prev_idle = (front_end[9:5] === 5'h00);
			@(posedge clk);
			n++;
			if (forbid >= 0 && fe_bit(forbid) === 1'b1)
				chk(0, 1, "phase seen that should be skipped");
		end while (fe_bit(sel) !== 1'b1 && n < LIM);
		chk(fe_bit(sel), 1, "phase never began");
		if (settle)
			chk(prev_idle, 1, "no settle gap before phase");
	endtask
	task automatic wait_off(input int sel);
		int n;
		n = 0;
		while (fe_bit(sel) === 1'b1 && n < LIM) begin
			@(posedge clk);
			n++;
		end
		chk(fe_bit(sel), 0, "phase never ended");
	endtask
	task automatic restart(input logic [31:0] ctrl);
		int n;
		n = 0;
		reset <= 1'b1;
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		while (!(panel.processor_supply === 1'b1 && panel.display_test === 1'b0) && n < LIM) begin
			@(posedge clk);
			n++;
		end
		chk(panel.processor_supply, 1, "start-up never ended");
		if (ctrl != 0)
			apb(1, lcr_seq_pkg::CTRL_OFS, ctrl);
	endtask
	task automatic poll_done();
		int n;
		n = 0;
		do begin
			apb(0, lcr_seq_pkg::STATUS_OFS, 0);
			n++;
		end while (rd[0] !== 1'b1 && n < 10000);
		chk(rd[0], 1, "measurement never completed");
	endtask
	task automatic scen_power();
		reset <= 1'b1;
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		chk(panel, 6'h03, "panel after reset");
		chk(front_end, 11'h003, "front end after reset");
		repeat (PU / 2) @(posedge clk);
		chk(panel.processor_supply, 0, "supply applied too early");
		wait_off(5);
		while (panel.processor_supply !== 1'b1 && cycles < 1000)
			@(posedge clk);
		chk(panel.display_test, 1, "display test not running");
		while (panel.display_test === 1'b1 && cycles < 1000) begin
			chk(front_end[9:5], 0, "measurement during display test");
			@(posedge clk);
		end
		apb(0, lcr_seq_pkg::CTRL_OFS, 0);
		chk(rd, 32'h147, "default mode not loaded");
		apb(0, 12'h010, 0);
		chk(err, 1, "unmapped read not refused");
		chk(rd, 0, "unmapped read data");
		apb(1, lcr_seq_pkg::RES_PRI_OFS, 32'h7ff);
		apb(0, lcr_seq_pkg::RES_PRI_OFS, 0);
		chk(rd, 0, "result register written");
		chk(err, 0, "result register read refused");
	endtask
	task automatic scen_sat();
		sat_cmd <= 1'b1;
		apb(1, lcr_seq_pkg::CTRL_OFS, 32'h187);
		wait_fe(0, -1, 1);
		chk(front_end[10:9], 2'b01, "null paths wrong");
		wait_off(0);
		sat_cmd <= 1'b0;
		wait_fe(0, 1, 1);
		chk(panel.range_ind, 4, "range not stepped up");
		chk(front_end.range_sel, 4, "range select not stepped up");
		chk(panel.blank, 1, "display not blanked while ranging");
	endtask
	task automatic scen_short();
		int n;
		n = 0;
		wait_fe(1, -1, 1);
		wait_fe(2, -1, 0);
		chk(front_end[6:5], 0, "integrator active during adjust");
		wait_fe(3, -1, 1);
		chk(front_end.signal_path, 1, "signal not applied");
		while (front_end.charge === 1'b1 && n < LIM) begin
			@(posedge clk);
			n++;
		end
		chk(n, lcr_seq_pkg::CHG_US_10K * lcr_seq_pkg::CLK_MHZ, "charge time");
		wait_fe(4, -1, 1);
		wait_off(4);
		wait_fe(0, 1, 1);
		chk(panel.range_ind, 3, "short count did not step range down");
		chk(panel.blank, 1, "blanking dropped while ranging");
		apb(0, lcr_seq_pkg::STATUS_OFS, 0);
		chk(rd[0], 0, "result taken outside window");
	endtask
	task automatic scen_manual();
		restart(32'h184);
		wait_fe(4, -1, 1);
		chk(front_end.phase_sel, 2'b00, "primary phase select");
		wait_off(4);
		wait_fe(4, -1, 1);
		chk(front_end.phase_sel, 2'b01, "dissipation phase select");
		poll_done();
		apb(0, lcr_seq_pkg::RES_PRI_OFS, 0);
		chk(rd, 3, "primary count");
		apb(0, lcr_seq_pkg::RES_DQ_OFS, 0);
		chk(rd, 5, "dissipation count");
		apb(0, lcr_seq_pkg::STATUS_OFS, 0);
		chk(rd[6:1], 6'h13, "manual status");
		chk(panel, 6'h22, "manual panel");
	endtask
	task automatic scen_res();
		apb(1, lcr_seq_pkg::CTRL_OFS, 32'h024);
		apb(1, lcr_seq_pkg::STATUS_OFS, 1);
		poll_done();
		chk(front_end.phase_sel, 2'b10, "series phase select");
		apb(1, lcr_seq_pkg::STATUS_OFS, 1);
		dq0 = dq_runs;
		poll_done();
		chk(dq_runs, dq0, "dissipation cycle run for resistance");
		chk(rd[7], 0, "measuring dissipation for resistance");
	endtask
	initial begin
		clk = 1'b0;
		reset = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		sat_cmd = 1'b0;
		ticks_pri = 16'h0003;
		ticks_dq = 16'h0005;
		num_errors = 0;
		compares = 0;
		cycles = 0;
		scen_power();
		scen_sat();
		scen_short();
		scen_manual();
		scen_res();
		complete_run();
	end
endmodule // lcr_integrator_sequencer_tb
